// [lcs_map.vh]
// Constants shared by the logic cluster, its cells and their registers
`ifndef LCS_MAP_VH
`define LCS_MAP_VH

`define LCS_CELLS 10
`define LCS_SEG_CELLS 5
`define LCS_LUT_INPUTS 4
`define LCS_LUT_BITS 16
`define LCS_REG_CLEAR 1'b0
`define LCS_REG_PRESET 1'b1
`define LCS_MODE_ARITH 1'b1
`define LCS_ALOAD_PRESET 1'b0
`define LCS_CLR_FIRST 1'b0
`define LCS_ENA_FIRST 1'b0
`define LCS_CARRY_ZERO 1'b0
`define LCS_CARRY_ONE 1'b1

`endif

// [lcs_cell.v]
// One logic cell: four-input lookup function or carry-select arithmetic slice
`default_nettype none
`include "lcs_map.vh"

module lcs_cell (
    input wire arith_mode,
    input wire op_a,
    input wire op_b,
    input wire carry_zero_assumed_in,
    input wire carry_one_assumed_in,
    input wire seg_carry_in,
    input wire [`LCS_LUT_INPUTS-1:0] lut_in,
    input wire [`LCS_LUT_BITS-1:0] lut_mask,
    output wire result,
    output wire carry_zero_out,
    output wire carry_one_out
);

    function carry_fn;
        input a;
        input b;
        input c;
        begin
            carry_fn = (a & b) | (c & (a | b));
        end
    endfunction

    wire sum_zero;
    wire sum_one;
    wire lut_out;

    // Any function of the four inputs
    assign lut_out = lut_mask[lut_in];

    // Two sums precomputed, one per assumed carry
    assign sum_zero = op_a ^ op_b ^ carry_zero_assumed_in;
    assign sum_one = op_a ^ op_b ^ carry_one_assumed_in;

    // Each incoming chain picks its own carry-out
    assign carry_zero_out = carry_fn(op_a, op_b, carry_zero_assumed_in);
    assign carry_one_out = carry_fn(op_a, op_b, carry_one_assumed_in);

    // Segment carry picks which precomputed sum is shown
    assign result = (arith_mode == `LCS_MODE_ARITH) ?
        (seg_carry_in ? sum_one : sum_zero) : lut_out;

endmodule
`default_nettype wire

// [lcs_reg.v]
// Cell register with clear, preset/load, clock enable and synchronous controls
`default_nettype none
`include "lcs_map.vh"

module lcs_reg (
    input wire sys_clk,
    input wire rst_b,
    input wire chip_clear_enable,
    input wire chip_wide_clear_n,
    input wire async_clear,
    input wire async_load,
    input wire async_load_data,
    input wire clock_enable,
    input wire sync_clear,
    input wire sync_load,
    input wire sync_load_data,
    input wire d,
    output reg q_ff
);

    reg nxt_q;

    always @* begin
        nxt_q = q_ff;
        if (chip_clear_enable && !chip_wide_clear_n) begin
            nxt_q = `LCS_REG_CLEAR;
        end else if (async_clear) begin
            nxt_q = `LCS_REG_CLEAR;
        end else if (async_load) begin
            nxt_q = async_load_data;
        end else if (clock_enable) begin
            if (sync_clear) begin
                nxt_q = `LCS_REG_CLEAR;
            end else if (sync_load) begin
                nxt_q = sync_load_data;
            end else begin
                nxt_q = d;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            q_ff <= `LCS_REG_CLEAR;
        end else begin
            q_ff <= nxt_q;
        end
    end

endmodule
`default_nettype wire

// [lcs_cluster.v]
// Ten-cell logic cluster with lookup chain and two-segment carry-select arithmetic
//
// Overview of operation
// - Normal mode: four data inputs feed a four-input lookup of any function.
// - Normal mode: a cell may take the previous cell's lookup output directly.
// - Register asynchronous load value comes from the fourth data input.
// - Register packing: register and lookup serve unrelated functions separately.
// - Arithmetic: sums and carry-outs computed for assumed carry zero and one.
// - Cluster carry-in picks a chain; that chain's level picks the sum.
// - Zero-chain carry selects zero carry-out; one-chain selects one carry-out.
// - Arithmetic: registered and unregistered sum copies available together.
// - Counter enable and up/down come from the cell's data inputs.
// - Synchronous clear and load are single cluster-wide controls.
// - Cluster add/subtract select chooses addition or subtraction.
// - Add/subtract select drives carry input of a chain's first cell only.
// - Both assumed carries pass from each bit to the next higher bit, except from cell 4 to cell 5.
// - A carry chain may start at any cell of the cluster.
// - Cluster carry selection happens only after the fifth and tenth cell.
// - Final chain carry leaves the cluster registered, as cluster_carry_out_ff.
// - Chains longer than ten cells continue into the adjacent cluster.
// - Preset is an asynchronous load of one, no inverting trick.
// - Asynchronous clear wins over preset or load asserted together.
// - At most two clear controls and one preset control per cluster.
// - Enabled, asserted chip-wide clear resets every register, overriding all.
// - Subtract inverts second operand and forces carry-in one at LSB.
// - Each register picks one of two clock enables; deasserted enable holds it, yet async clear and load still act.
`default_nettype none
`include "lcs_map.vh"

module lcs_cluster #(
    parameter N = `LCS_CELLS,
    parameter SEG = `LCS_SEG_CELLS
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [N-1:0] first_operand_input,
    input wire [N-1:0] second_operand_input,
    input wire [N-1:0] third_data_input,
    input wire [N-1:0] fourth_data_input,
    input wire cluster_carry_in,
    input wire cluster_add_sub,
    input wire cluster_sync_clear,
    input wire cluster_sync_load,
    input wire cluster_clock_enable_first,
    input wire cluster_clock_enable_second,
    input wire cluster_async_clear_first,
    input wire cluster_async_clear_second,
    input wire cluster_async_load,
    input wire cfg_aload_mode,
    input wire chip_clear_enable,
    input wire chip_wide_clear_n,
    input wire [`LCS_LUT_BITS*N-1:0] cfg_lut_mask,
    input wire [N-1:0] cfg_arith_mode,
    input wire [N-1:0] cfg_counter,
    input wire [N-1:0] cfg_chain_start,
    input wire [N-1:0] cfg_lut_chain,
    input wire [N-1:0] cfg_carry_to_lut,
    input wire [N-1:0] cfg_pack,
    input wire [N-1:0] cfg_clr_en,
    input wire [N-1:0] cfg_clr_sel,
    input wire [N-1:0] cfg_ena_sel,
    output wire [N-1:0] cell_reg_q,
    output reg [N-1:0] cell_comb_q_ff,
    output reg cluster_carry_out_ff
);

    function sel_carry;
        input sel;
        input c_zero;
        input c_one;
        begin
            sel_carry = sel ? c_one : c_zero;
        end
    endfunction

    wire [N-1:0] comb;
    wire [N-1:0] co_zero;
    wire [N-1:0] co_one;
    wire [N-1:0] ci_zero;
    wire [N-1:0] ci_one;
    wire [N-1:0] seg_cin;
    wire seg_hi_cin;
    wire cluster_carry_out;
    reg [N-1:0] nxt_comb_q;
    reg nxt_carry_out;

    // Second segment's carry-in is the first segment's selected carry-out
    assign seg_hi_cin = sel_carry(cluster_carry_in, co_zero[SEG-1], co_one[SEG-1]);
    // Next cluster's carry-in; chain continues vertically
    assign cluster_carry_out = sel_carry(seg_hi_cin, co_zero[N-1], co_one[N-1]);

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_cell
            wire arith;
            wire count_en;
            wire count_up;
            wire start_carry;
            wire op_a;
            wire op_b;
            wire chain_carry;
            wire [`LCS_LUT_INPUTS-1:0] lut_in;
            wire reg_d;
            wire aload_data;
            wire clr_ctl;
            wire ena_ctl;

            assign arith = (cfg_arith_mode[i] == `LCS_MODE_ARITH);
            // Counter controls arrive on the cell's own data inputs
            assign count_en = third_data_input[i];
            assign count_up = fourth_data_input[i];

            // Carry forced into a chain's first cell only
            assign start_carry = cfg_counter[i] ? (count_en & count_up) :
                cluster_add_sub;

            assign op_a = cfg_counter[i] ? cell_reg_q[i] : first_operand_input[i];
            // Down count adds all ones; subtract adds inverted operand
            assign op_b = cfg_counter[i] ? (count_en & ~count_up) :
                (second_operand_input[i] ^ cluster_add_sub);

            if (i == 0) begin : g_first
                assign ci_zero[i] = cfg_chain_start[i] ? start_carry :
                    `LCS_CARRY_ZERO;
                assign ci_one[i] = cfg_chain_start[i] ? start_carry :
                    `LCS_CARRY_ONE;
                assign seg_cin[i] = cluster_carry_in;
            end else if (i == SEG) begin : g_seg
                // Chains restart so only the selection point is on the long path
                assign ci_zero[i] = cfg_chain_start[i] ? start_carry :
                    `LCS_CARRY_ZERO;
                assign ci_one[i] = cfg_chain_start[i] ? start_carry :
                    `LCS_CARRY_ONE;
                assign seg_cin[i] = seg_hi_cin;
            end else begin : g_mid
                assign ci_zero[i] = cfg_chain_start[i] ? start_carry :
                    co_zero[i-1];
                assign ci_one[i] = cfg_chain_start[i] ? start_carry :
                    co_one[i-1];
                assign seg_cin[i] = seg_cin[i-1];
            end

            // Selected carry seen by this cell, usable by a normal-mode cell
            assign chain_carry = sel_carry(seg_cin[i], ci_zero[i], ci_one[i]);

            if (i == 0) begin : g_lut0
                assign lut_in = {cfg_carry_to_lut[i] ? chain_carry : fourth_data_input[i],
                    third_data_input[i], second_operand_input[i],
                    first_operand_input[i]};
            end else begin : g_lutn
                // Lookup chain replaces the third input with the cell above
                assign lut_in = {cfg_carry_to_lut[i] ? chain_carry : fourth_data_input[i],
                    cfg_lut_chain[i] ? comb[i-1] : third_data_input[i],
                    second_operand_input[i], first_operand_input[i]};
            end

            lcs_cell u_cell (
                .arith_mode(cfg_arith_mode[i]),
                .op_a(op_a),
                .op_b(op_b),
                .carry_zero_assumed_in(ci_zero[i]),
                .carry_one_assumed_in(ci_one[i]),
                .seg_carry_in(seg_cin[i]),
                .lut_in(lut_in),
                .lut_mask(cfg_lut_mask[`LCS_LUT_BITS*i +: `LCS_LUT_BITS]),
                .result(comb[i]),
                .carry_zero_out(co_zero[i]),
                .carry_one_out(co_one[i])
            );

            // Packed register takes a direct input while lookup output goes out apart
            assign reg_d = (!arith && cfg_pack[i]) ? fourth_data_input[i] : comb[i];
            // Preset is a load of one; otherwise load the fourth data input
            assign aload_data = (cfg_aload_mode == `LCS_ALOAD_PRESET) ?
                `LCS_REG_PRESET : fourth_data_input[i];
            // Only two clears and one preset/load exist per cluster
            assign clr_ctl = cfg_clr_en[i] & ((cfg_clr_sel[i] == `LCS_CLR_FIRST) ?
                cluster_async_clear_first : cluster_async_clear_second);
            assign ena_ctl = (cfg_ena_sel[i] == `LCS_ENA_FIRST) ?
                cluster_clock_enable_first : cluster_clock_enable_second;

            lcs_reg u_reg (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .chip_clear_enable(chip_clear_enable),
                .chip_wide_clear_n(chip_wide_clear_n),
                .async_clear(clr_ctl),
                .async_load(cluster_async_load),
                .async_load_data(aload_data),
                .clock_enable(ena_ctl),
                .sync_clear(cluster_sync_clear),
                .sync_load(cluster_sync_load),
                .sync_load_data(third_data_input[i]),
                .d(reg_d),
                .q_ff(cell_reg_q[i])
            );
        end
    endgenerate

    // Unregistered copies retimed so every top output is a flop; not gated by enable
    always @* begin
        nxt_comb_q = comb;
        nxt_carry_out = cluster_carry_out;
        if (chip_clear_enable && !chip_wide_clear_n) begin
            nxt_comb_q = {N{`LCS_REG_CLEAR}};
            nxt_carry_out = `LCS_REG_CLEAR;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            cell_comb_q_ff <= {N{`LCS_REG_CLEAR}};
            cluster_carry_out_ff <= `LCS_REG_CLEAR;
        end else begin
            cell_comb_q_ff <= nxt_comb_q;
            cluster_carry_out_ff <= nxt_carry_out;
        end
    end

endmodule
`default_nettype wire

// [lcs_nbr_model.sv]
// Lower-order neighbour cluster that hands its carry into this cluster
`default_nettype none
module lcs_nbr_model #(
    parameter int N = 10
) (
    input wire logic [N-1:0] low_a,
    input wire logic [N-1:0] low_b,
    output logic carry_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N:0] total;
    // Full-width sum, so the carry is exact and not guessed from the top bits
    assign total = {1'b0, low_a} + {1'b0, low_b};
    assign carry_out = total[N];
endmodule
`default_nettype wire

// [lcs_cluster_props.sv]
// Concurrent checks on the cluster ports
`default_nettype none
module lcs_cluster_props #(
    parameter N = 10,
    parameter SEG = 5
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [N-1:0] first_operand_input,
    input wire [N-1:0] second_operand_input,
    input wire [N-1:0] third_data_input,
    input wire [N-1:0] fourth_data_input,
    input wire cluster_carry_in,
    input wire cluster_add_sub,
    input wire cluster_sync_clear,
    input wire cluster_sync_load,
    input wire cluster_clock_enable_first,
    input wire cluster_clock_enable_second,
    input wire cluster_async_clear_first,
    input wire cluster_async_clear_second,
    input wire cluster_async_load,
    input wire cfg_aload_mode,
    input wire chip_clear_enable,
    input wire chip_wide_clear_n,
    input wire [N-1:0] cfg_arith_mode,
    input wire [N-1:0] cfg_counter,
    input wire [N-1:0] cfg_chain_start,
    input wire [N-1:0] cfg_clr_en,
    input wire [N-1:0] cfg_clr_sel,
    input wire [N-1:0] cfg_ena_sel,
    input wire [N-1:0] cell_reg_q,
    input wire [N-1:0] cell_comb_q_ff,
    input wire cluster_carry_out_ff
);
    wire chip = chip_clear_enable && !chip_wide_clear_n;
    wire [N-1:0] clr = cfg_clr_en & (cfg_clr_sel & {N{cluster_async_clear_second}}
        | ~cfg_clr_sel & {N{cluster_async_clear_first}});
    wire [N-1:0] ena = cfg_ena_sel & {N{cluster_clock_enable_second}}
        | ~cfg_ena_sel & {N{cluster_clock_enable_first}};
    wire calm = !chip && clr == 0 && !cluster_async_load;
    // Only cell 0 may start a chain here, so cell 5 continues from cell 4's carry
    wire [N:0] sum = {1'b0, first_operand_input}
        + {1'b0, second_operand_input ^ {N{cluster_add_sub}}}
        + (cfg_chain_start[0] ? cluster_add_sub : cluster_carry_in);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_adder;
        !chip && cfg_arith_mode == '1 && cfg_counter == 0 && cfg_chain_start[N-1:1] == 0;
    endsequence
    sequence s_plain;
        calm && !cluster_sync_clear && !cluster_sync_load && ena == '1;
    endsequence
    property p_chip;
        chip |=> cell_reg_q == 0 && cell_comb_q_ff == 0 && !cluster_carry_out_ff;
    endproperty
    a_chip: assert property (p_chip) else $error("chip clear missed");
    property p_aclr;
        cluster_async_load |=> (cell_reg_q & $past(clr)) == 0;
    endproperty
    a_aclr: assert property (p_aclr) else $error("clear lost to load");
    property p_preset;
        !chip && cluster_async_load && !cfg_aload_mode |=> (cell_reg_q | $past(clr)) == '1;
    endproperty
    a_preset: assert property (p_preset) else $error("preset missed");
    property p_aload;
        !chip && cluster_async_load && cfg_aload_mode
            |=> ((cell_reg_q ^ $past(fourth_data_input)) & ~$past(clr)) == 0;
    endproperty
    a_aload: assert property (p_aload) else $error("load data wrong");
    property p_hold;
        calm |=> ((cell_reg_q ^ $past(cell_reg_q)) & ~$past(ena)) == 0;
    endproperty
    a_hold: assert property (p_hold) else $error("disabled cell moved");
    property p_sclr;
        calm && cluster_sync_clear |=> (cell_reg_q & $past(ena)) == 0;
    endproperty
    a_sclr: assert property (p_sclr) else $error("sync clear missed");
    property p_sload;
        calm && !cluster_sync_clear && cluster_sync_load
            |=> ((cell_reg_q ^ $past(third_data_input)) & $past(ena)) == 0;
    endproperty
    a_sload: assert property (p_sload) else $error("sync load wrong");
    property p_add;
        s_adder |=> {cluster_carry_out_ff, cell_comb_q_ff} == $past(sum);
    endproperty
    a_add: assert property (p_add) else $error("sum wrong");
    property p_copy;
        s_adder ##0 s_plain |=> cell_reg_q == cell_comb_q_ff;
    endproperty
    a_copy: assert property (p_copy) else $error("copies differ");
endmodule
bind lcs_cluster lcs_cluster_props #(.N(N), .SEG(SEG)) u_props (.*);
`default_nettype wire

// [lcs_cluster_tb.sv]
// Self-checking bench for the ten-cell logic cluster
`default_nettype none
module lcs_cluster_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 10;
    `define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin fail_count++; \
        $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
    logic sys_clk, rst_b, cluster_add_sub, cluster_sync_clear, cluster_sync_load;
    logic cluster_clock_enable_first, cluster_clock_enable_second, cluster_async_load;
    logic cluster_async_clear_first, cluster_async_clear_second, cfg_aload_mode;
    logic chip_clear_enable, chip_wide_clear_n, e0, cnt_en, cnt_up;
    logic [N-1:0] first_operand_input, second_operand_input, third_data_input;
    logic [N-1:0] fourth_data_input, cfg_arith_mode, cfg_counter, cfg_chain_start;
    logic [N-1:0] cfg_lut_chain, cfg_carry_to_lut, cfg_pack, cfg_clr_en, cfg_clr_sel;
    logic [N-1:0] cfg_ena_sel, low_a, low_b;
    logic [16*N-1:0] cfg_lut_mask;
    logic [N:0] ex;
    wire [N-1:0] cell_reg_q, cell_comb_q_ff;
    wire cluster_carry_out_ff, cluster_carry_in;
    int fail_count = 0, n_checks = 0, cycles = 0;

    lcs_cluster uut (.*);
    lcs_nbr_model #(.N(N)) nbr (.low_a, .low_b, .carry_out(cluster_carry_in));

    function automatic logic [N:0] f_sum(logic [N-1:0] a, b, logic sub, cin);
        return {1'b0, a} + {1'b0, b ^ {N{sub}}} + (N+1)'(cin);
    endfunction

    // Up adds one, down subtracts one, disabled holds
    function automatic logic [N-1:0] f_count(logic [N-1:0] q, logic en, up);
        return en ? (up ? q + 1'b1 : q - 1'b1) : q;
    endfunction

    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        sys_clk = 0;
        forever #20 sys_clk = ~sys_clk;
    end

    // About 620 cycles are needed; a hang stops well past that
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'hB6D7FA69));
        rst_b = 0;
        {cluster_sync_clear, cluster_sync_load, cluster_async_load, cluster_async_clear_first,
            cluster_async_clear_second, chip_clear_enable, cfg_aload_mode, cluster_add_sub} = '0;
        {cluster_clock_enable_first, cluster_clock_enable_second, chip_wide_clear_n} = '1;
        {first_operand_input, second_operand_input, third_data_input, fourth_data_input} = '0;
        {cfg_counter, cfg_lut_chain, cfg_carry_to_lut, cfg_pack, cfg_clr_en, cfg_clr_sel} = '0;
        {cfg_ena_sel, low_a, low_b, cfg_lut_mask, cfg_chain_start} = '0;
        cfg_arith_mode = '1;
        repeat (20) @(negedge sys_clk);
        rst_b = 1;
        // Adder/subtractor with register controls firing now and then
        for (int k = 0; k < 400; k++) begin
            {first_operand_input, second_operand_input, third_data_input, fourth_data_input,
                low_a, low_b} = {$urandom, $urandom};
            {cfg_clr_en, cfg_clr_sel, cfg_ena_sel, cfg_aload_mode} = $urandom;
            {cluster_sync_clear, cluster_sync_load, cluster_async_load, cluster_async_clear_first,
                cluster_async_clear_second} = $urandom & $urandom & $urandom;
            {cluster_clock_enable_first, cluster_clock_enable_second, chip_wide_clear_n} =
                $urandom | $urandom;
            {chip_clear_enable, cluster_add_sub, cfg_chain_start} = $urandom & 32'hC01;
            // Ripple across all cells and across the cell 4 to 5 boundary
            if (k < 4) begin
                first_operand_input = k[0] ? 10'h01F : 10'h3FF;
                second_operand_input = 10'h001;
                cluster_add_sub = k[1];
                {chip_clear_enable, cfg_chain_start} = 11'h001;
            end
            @(negedge sys_clk);
            if (!(chip_clear_enable && !chip_wide_clear_n)) begin
                ex = f_sum(first_operand_input, second_operand_input, cluster_add_sub,
                    cfg_chain_start[0] ? cluster_add_sub : cluster_carry_in);
                `CHK("sum", ex[N-1:0], cell_comb_q_ff)
                `CHK("carry out", ex[N], cluster_carry_out_ff)
            end
        end
        // Lookup mode, chained lookup into cell 1 and packed registers
        {cfg_arith_mode, cfg_chain_start, cfg_clr_en, cluster_async_load, cluster_sync_clear,
            cluster_sync_load, chip_clear_enable} = '0;
        {cluster_clock_enable_first, cluster_clock_enable_second} = '1;
        cfg_lut_chain = 10'h002;
        repeat (100) begin
            for (int j = 0; j < 5; j++)
                cfg_lut_mask[32*j+:32] = $urandom;
            {first_operand_input, second_operand_input, third_data_input, fourth_data_input,
                cfg_pack} = {$urandom, $urandom};
            // Carry arriving from the neighbour may replace the fourth lookup input
            {low_a, low_b, cfg_carry_to_lut[0]} = $urandom;
            @(negedge sys_clk);
            e0 = cfg_lut_mask[{cfg_carry_to_lut[0] ? cluster_carry_in : fourth_data_input[0],
                third_data_input[0], second_operand_input[0], first_operand_input[0]}];
            ex[0] = cfg_lut_mask[16 + {fourth_data_input[1], e0, second_operand_input[1],
                first_operand_input[1]}];
            `CHK("lookup", e0, cell_comb_q_ff[0])
            `CHK("chained lookup", ex[0], cell_comb_q_ff[1])
            `CHK("packed", fourth_data_input & cfg_pack, cell_reg_q & cfg_pack)
        end
        // Counter in every cell; load all ones first so the count wraps across both segments
        {cfg_lut_chain, cfg_carry_to_lut, cfg_pack} = '0;
        {cfg_arith_mode, cfg_counter} = '1;
        cfg_chain_start = 10'h001;
        for (int k = 0; k < 100; k++) begin
            {cnt_en, cnt_up} = (k < 3) ? 2'b11 : 2'($urandom);
            cluster_sync_load = (k == 0);
            third_data_input = {N{cnt_en}};
            fourth_data_input = {N{cnt_up}};
            ex[N-1:0] = (k == 0) ? {N{1'b1}} : f_count(cell_reg_q, cnt_en, cnt_up);
            @(negedge sys_clk);
            `CHK("counter", ex[N-1:0], cell_reg_q)
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
